// ===== pkg/fsim_pkg.sv
// Constants, register map and timing figures for the framer status and interrupt-mask block.
package fsim_pkg;

    // ==========================================================
    // Register bus and map.
    localparam int unsigned ADDR_W              = 8;
    localparam int unsigned DATA_W              = 8;
    localparam logic [7:0]  EVENT_STATUS_TWO_OFS = 8'h21;
    localparam logic [7:0]  EVENT_MASK_TWO_OFS   = 8'h6f;
    localparam logic [7:0]  ALARM_MASK_ONE_OFS   = 8'h7f;

    // ==========================================================
    // Reset values; masks come up blocking every event.
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;

    // ==========================================================
    // Bit positions of the event status and event mask registers.
    localparam int unsigned RX_MULTIFRAME_BIT = 7;
    localparam int unsigned TX_MULTIFRAME_BIT = 6;
    localparam int unsigned ONE_SECOND_BIT    = 5;
    localparam int unsigned RX_LINK_FULL_BIT  = 4;
    localparam int unsigned TX_LINK_EMPTY_BIT = 3;
    localparam int unsigned RX_LINK_MATCH_BIT = 2;
    localparam int unsigned RX_LINK_ABORT_BIT = 1;
    localparam int unsigned SIG_CHANGE_BIT    = 0;

    // ==========================================================
    // Bit positions of the alarm mask register.
    localparam int unsigned LOOP_UP_BIT       = 7;
    localparam int unsigned LOOP_DOWN_BIT     = 6;
    localparam int unsigned TX_CLOCK_LOSS_BIT = 5;
    localparam int unsigned ELASTIC_ELASTIC_STORE_A_BIT  = 4;
    localparam int unsigned BLUE_ALARM_BIT    = 3;
    localparam int unsigned YELLOW_ALARM_BIT  = 2;
    localparam int unsigned CARRIER_LOSS_BIT  = 1;
    localparam int unsigned RX_SYNC_LOSS_BIT  = 0;

    // ==========================================================
    // Data link figures.
    localparam int unsigned LINK_BYTE_BITS = 8;
    localparam int unsigned ABORT_ONES     = 8;
    localparam int unsigned LINK_CNT_W     = 4;

    // ==========================================================
    // One-second pacing, counted in receive line bit strobes.
    localparam int unsigned RX_LINE_RATE_HZ = 1544000;
    localparam int unsigned SEC_SHORT_MS    = 999;
    localparam int unsigned SEC_LONG_MS     = 1002;
    localparam int unsigned SEC_SHORT_BITS  = SEC_SHORT_MS * RX_LINE_RATE_HZ / 1000;
    localparam int unsigned SEC_LONG_BITS   = SEC_LONG_MS * RX_LINE_RATE_HZ / 1000;
    localparam int unsigned SEC_CNT_W       = 22;
    localparam logic [1:0]  SEC_LONG_PHASE  = 2'h2;

endpackage : fsim_pkg

// ===== rtl/fsim_sec_timer.sv
// One-second tick generator paced by receive line bit strobes.
`timescale 1ns/1ps

module fsim_sec_timer
    import fsim_pkg::*;
#(
    parameter int unsigned SHORT_BITS = SEC_SHORT_BITS,
    parameter int unsigned LONG_BITS  = SEC_LONG_BITS
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Receive line bit strobe.
    input  wire logic bit_stb_i,
    // One-cycle tick.
    output logic      tick_o
);

    localparam logic [SEC_CNT_W-1:0] SHORT_M1 = SEC_CNT_W'(SHORT_BITS - 1);
    localparam logic [SEC_CNT_W-1:0] LONG_M1  = SEC_CNT_W'(LONG_BITS - 1);

    logic [SEC_CNT_W-1:0] cnt_reg, cnt_next;     // Strobes in the running interval.
    logic [1:0]           phase_reg, phase_next; // Which of the three intervals runs.
    logic                 tick_next;             // Next tick value.
    logic [SEC_CNT_W-1:0] limit_m1;              // Last count of this interval.

    // ==========================================================
    // The third interval is longer so three ticks span three seconds exactly.
    always_comb begin
        limit_m1   = (phase_reg == SEC_LONG_PHASE) ? LONG_M1 : SHORT_M1;
        cnt_next   = cnt_reg;
        phase_next = phase_reg;
        tick_next  = 1'b0;
        if (bit_stb_i) begin
            if (cnt_reg == limit_m1) begin
                cnt_next   = '0;
                tick_next  = 1'b1;
                phase_next = (phase_reg == SEC_LONG_PHASE) ? 2'h0 : phase_reg + 2'h1;
            end else begin
                cnt_next = cnt_reg + SEC_CNT_W'(1);
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            phase_reg <= 2'h0;
            tick_o    <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            phase_reg <= phase_next;
            tick_o    <= tick_next;
        end
    end

    // ==========================================================
    // Independent strobe tally checks each interval length.
    logic [SEC_CNT_W-1:0] h_cnt;
    logic [1:0]           h_phase;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            h_cnt   <= '0;
            h_phase <= 2'h0;
        end else begin
            h_cnt   <= (tick_o ? '0 : h_cnt) + SEC_CNT_W'(bit_stb_i);
            h_phase <= tick_o ? ((h_phase == 2'h2) ? 2'h0 : h_phase + 2'h1) : h_phase;
        end
    end

    a_sec_interval_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tick_o |-> (h_cnt == ((h_phase == 2'h2) ? SEC_CNT_W'(LONG_BITS) : SEC_CNT_W'(SHORT_BITS))))
        else $error("one-second interval has wrong length");

    c_sec_long_tick: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        tick_o && h_phase == 2'h2);

endmodule : fsim_sec_timer

// ===== rtl/fsim_link_rx.sv
// Receive data link monitor: buffer fill and abort detection.
`timescale 1ns/1ps

module fsim_link_rx
    import fsim_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Received link bit and its strobe.
    input  wire logic bit_stb_i,
    input  wire logic bit_i,
    // One-cycle events.
    output logic      full_o,
    output logic      abort_o
);

    localparam logic [LINK_CNT_W-1:0] FILL_M1 = LINK_CNT_W'(LINK_BYTE_BITS - 1);
    localparam logic [LINK_CNT_W-1:0] ONES_M1 = LINK_CNT_W'(ABORT_ONES - 1);

    logic [LINK_CNT_W-1:0] fill_reg, fill_next; // Bits held in the buffer.
    logic [LINK_CNT_W-1:0] ones_reg, ones_next; // Current run of ones.
    logic                  full_next;           // Next full event.
    logic                  abort_next;          // Next abort event.

    // ==========================================================
    // A run of ones restarts after each abort so a long idle of ones keeps reporting.
    always_comb begin
        fill_next  = fill_reg;
        ones_next  = ones_reg;
        full_next  = 1'b0;
        abort_next = 1'b0;
        if (bit_stb_i) begin
            if (fill_reg == FILL_M1) begin
                fill_next = '0;
                full_next = 1'b1;
            end else begin
                fill_next = fill_reg + LINK_CNT_W'(1);
            end
            if (!bit_i) begin
                ones_next = '0;
            end else if (ones_reg == ONES_M1) begin
                ones_next  = '0;
                abort_next = 1'b1;
            end else begin
                ones_next = ones_reg + LINK_CNT_W'(1);
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fill_reg <= '0;
            ones_reg <= '0;
            full_o   <= 1'b0;
            abort_o  <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            ones_reg <= ones_next;
            full_o   <= full_next;
            abort_o  <= abort_next;
        end
    end

endmodule : fsim_link_rx

// ===== rtl/fsim_status_irq.sv
// Top of the framer event status and interrupt-mask block.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module fsim_status_irq
    import fsim_pkg::*;
#(
    parameter int unsigned SIG_W          = 48,
    parameter int unsigned SEC_SHORT_CNT  = SEC_SHORT_BITS,
    parameter int unsigned SEC_LONG_CNT   = SEC_LONG_BITS
) (
    // Clock and reset.
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    // Register port.
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [DATA_W-1:0] RDATA_O,
    // Framer events, all from logic on this clock.
    input  wire logic              RX_MULTIFRAME_I,
    input  wire logic              TX_MULTIFRAME_I,
    input  wire logic              RX_BIT_STB_I,
    input  wire logic              RX_LINK_STB_I,
    input  wire logic              RX_LINK_BIT_I,
    input  wire logic              RX_LINK_MATCH_I,
    input  wire logic              TX_LINK_EMPTY_I,
    input  wire logic              SIG_STB_I,
    input  wire logic [SIG_W-1:0]  SIG_BITS_I,
    // Alarm flags held by the first status register outside.
    input  wire logic [DATA_W-1:0] ALARM_STATUS_I,
    // Interrupt.
    output logic                   IRQ_O
);

    // ==========================================================
    // Declarations.
    logic              sec_tick;                  // One-second tick pulse.
    logic              link_full;                 // Receive link buffer full pulse.
    logic              link_abort;                // Receive link abort pulse.
    logic              tx_empty_reg;              // Previous level of the empty line.
    logic              tx_empty_next;             // Next value of that level.
    logic [SIG_W-1:0]  sig_prev_reg, sig_prev_next; // Last signaling sample.
    logic              sig_seen_reg, sig_seen_next; // A first sample is held.
    logic              sig_change;                // Signaling bits moved.
    logic [DATA_W-1:0] events;                    // This cycle's event pulses.
    logic [DATA_W-1:0] status_reg, status_next;   // Sticky event flags.
    logic [DATA_W-1:0] mask2_reg, mask2_next;     // Event mask.
    logic [DATA_W-1:0] mask1_reg, mask1_next;     // Alarm mask.
    logic [DATA_W-1:0] rdata_next;                // Next read data.
    logic              irq_next;                  // Next interrupt level.
    logic              wr_status;                 // Write hits the status register.

    // ==========================================================
    // Event sources.

    // Interval timer paced by the receive line, not by the system clock.
    fsim_sec_timer #(
        .SHORT_BITS (SEC_SHORT_CNT),
        .LONG_BITS  (SEC_LONG_CNT)
    ) u_sec (
        .clk_i     (CLK_I),
        .rst_n_i   (RST_N_I),
        .bit_stb_i (RX_BIT_STB_I),
        .tick_o    (sec_tick)
    );

    // Receive link fill and abort watcher.
    fsim_link_rx u_link (
        .clk_i     (CLK_I),
        .rst_n_i   (RST_N_I),
        .bit_stb_i (RX_LINK_STB_I),
        .bit_i     (RX_LINK_BIT_I),
        .full_o    (link_full),
        .abort_o   (link_abort)
    );

    // The first sample after reset only primes the comparison, so power-up
    // never reports a change that did not happen.
    always_comb begin
        sig_prev_next = sig_prev_reg;
        sig_seen_next = sig_seen_reg;
        sig_change    = 1'b0;
        tx_empty_next = TX_LINK_EMPTY_I;
        if (SIG_STB_I) begin
            sig_change    = sig_seen_reg && (SIG_BITS_I != sig_prev_reg);
            sig_prev_next = SIG_BITS_I;
            sig_seen_next = 1'b1;
        end
    end

    // Registers only.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sig_prev_reg <= '0;
            sig_seen_reg <= 1'b0;
            tx_empty_reg <= 1'b1; // An empty buffer at reset is no new edge.
        end else begin
            sig_prev_reg <= sig_prev_next;
            sig_seen_reg <= sig_seen_next;
            tx_empty_reg <= tx_empty_next;
        end
    end

    // Event vector in status bit order.
    always_comb begin
        events                    = '0;
        events[RX_MULTIFRAME_BIT] = RX_MULTIFRAME_I;
        events[TX_MULTIFRAME_BIT] = TX_MULTIFRAME_I;
        events[ONE_SECOND_BIT]    = sec_tick;
        events[RX_LINK_FULL_BIT]  = link_full;
        events[TX_LINK_EMPTY_BIT] = TX_LINK_EMPTY_I && !tx_empty_reg;
        events[RX_LINK_MATCH_BIT] = RX_LINK_MATCH_I;
        events[RX_LINK_ABORT_BIT] = link_abort;
        events[SIG_CHANGE_BIT]    = sig_change;
    end

    // ==========================================================
    // Register file.

    // A new event beats a clear written in the same cycle, so no event is lost.
    always_comb begin
        wr_status   = WR_I && (ADDR_I == EVENT_STATUS_TWO_OFS);
        status_next = (status_reg & ~(wr_status ? WDATA_I : '0)) | events;
        mask2_next  = mask2_reg;
        mask1_next  = mask1_reg;
        rdata_next  = '0;
        if (WR_I && ADDR_I == EVENT_MASK_TWO_OFS) begin
            mask2_next = WDATA_I;
        end
        if (WR_I && ADDR_I == ALARM_MASK_ONE_OFS) begin
            mask1_next = WDATA_I;
        end
        // Unmapped reads answer zero; data stand one cycle only.
        if (RD_I) begin
            unique case (ADDR_I)
                EVENT_STATUS_TWO_OFS: rdata_next = status_reg;
                EVENT_MASK_TWO_OFS:   rdata_next = mask2_reg;
                ALARM_MASK_ONE_OFS:   rdata_next = mask1_reg;
                default:              rdata_next = '0;
            endcase
        end
    end

    // The interrupt follows the registered flags one cycle late; the trade
    // buys an output that comes straight from a flip-flop.
    always_comb begin
        irq_next = |(status_reg & mask2_reg)
                 | |(ALARM_STATUS_I & mask1_reg);
    end

    // Registers only.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            status_reg <= STATUS_RST;
            mask2_reg  <= MASK_RST;
            mask1_reg  <= MASK_RST;
            RDATA_O    <= '0;
            IRQ_O      <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask2_reg  <= mask2_next;
            mask1_reg  <= mask1_next;
            RDATA_O    <= rdata_next;
            IRQ_O      <= irq_next;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_sec_sets_flag: assert property (
        sec_tick |=> status_reg[ONE_SECOND_BIT])
        else $error("one-second tick did not set its flag");

    a_full_on_strobe: assert property (
        link_full |-> $past(RX_LINK_STB_I))
        else $error("link full without a received bit");

    a_full_flag_held: assert property (
        link_full |=> status_reg[RX_LINK_FULL_BIT])
        else $error("link full did not set its flag");

    a_empty_sets_flag: assert property (
        $rose(TX_LINK_EMPTY_I) && $past(RST_N_I) |=> status_reg[TX_LINK_EMPTY_BIT])
        else $error("transmit empty did not set its flag");

    a_abort_run: assert property (
        link_abort |-> $past(RX_LINK_STB_I && RX_LINK_BIT_I)
        ##1 status_reg[RX_LINK_ABORT_BIT])
        else $error("abort not raised by a received one or not flagged");

    a_sig_change: assert property (
        SIG_STB_I && sig_seen_reg && SIG_BITS_I != sig_prev_reg
        |=> status_reg[SIG_CHANGE_BIT])
        else $error("signaling change not flagged");

    a_mask_blocks: assert property (
        ((status_reg & mask2_reg) == '0) && ((ALARM_STATUS_I & mask1_reg) == '0)
        |=> !IRQ_O)
        else $error("masked events raised the interrupt");

    a_alarm_enables: assert property (
        |(ALARM_STATUS_I[7:1] & mask1_reg[7:1]) |=> IRQ_O)
        else $error("enabled alarm did not interrupt");

    a_sync_loss_irq: assert property (
        ALARM_STATUS_I[RX_SYNC_LOSS_BIT] && mask1_reg[RX_SYNC_LOSS_BIT] |=> IRQ_O)
        else $error("sync loss did not interrupt");

    a_mask2_write: assert property (
        WR_I && ADDR_I == EVENT_MASK_TWO_OFS |=> mask2_reg == $past(WDATA_I))
        else $error("event mask write lost");

    a_irq_follows: assert property (
        |(status_reg & mask2_reg) |=> IRQ_O ##0 $past(status_reg, 1) != '0)
        else $error("enabled flag did not hold the interrupt");

    a_set_beats_clear: assert property (
        wr_status && WDATA_I[SIG_CHANGE_BIT] && sig_change |=> status_reg[SIG_CHANGE_BIT])
        else $error("clear beat a new event");

    a_read_data: assert property (
        RD_I && ADDR_I == EVENT_STATUS_TWO_OFS |=> RDATA_O == $past(status_reg) ##1
        ($past(RD_I) || RDATA_O == '0))
        else $error("status read data wrong");

    c_irq_rise: cover property ($rose(IRQ_O));
    c_abort_seen: cover property (link_abort);
    c_sig_seen: cover property (sig_change);
    c_collision: cover property (wr_status && (WDATA_I & events) != '0);

endmodule : fsim_status_irq

// ===== tb/testbench.sv
// Self-checking testbench for the framer event status and interrupt-mask block.
`timescale 1ns/1ps

module testbench;
    import fsim_pkg::*;

    // ==========================================================
    // Short counts keep the one-second pacing inside a brief run.
    localparam int unsigned SIG_W_TB = 8;
    localparam int unsigned SHORT_TB = 5;
    localparam int unsigned LONG_TB  = 7;

    // Clock, reset and register port.
    logic                CLK_I;
    logic                RST_N_I;
    logic [ADDR_W-1:0]   ADDR_I;
    logic [DATA_W-1:0]   WDATA_I;
    logic                WR_I;
    logic                RD_I;
    logic [DATA_W-1:0]   RDATA_O;
    // Framer events and interrupt.
    logic                RX_MULTIFRAME_I;
    logic                TX_MULTIFRAME_I;
    logic                RX_BIT_STB_I;
    logic                RX_LINK_STB_I;
    logic                RX_LINK_BIT_I;
    logic                RX_LINK_MATCH_I;
    logic                TX_LINK_EMPTY_I;
    logic                SIG_STB_I;
    logic [SIG_W_TB-1:0] SIG_BITS_I;
    logic [DATA_W-1:0]   ALARM_STATUS_I;
    logic                IRQ_O;
    // Bench bookkeeping.
    int                  err_total;
    int                  checked;
    logic [7:0]          d;
    int                  row_ev  [5] = '{0, 1, 2, 3, 4};
    logic [7:0]          row_exp [5] = '{8'h80, 8'h40, 8'h04, 8'h08, 8'h01};

    fsim_status_irq #(.SIG_W(SIG_W_TB), .SEC_SHORT_CNT(SHORT_TB), .SEC_LONG_CNT(LONG_TB))
    i_fsim_status_irq (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RX_MULTIFRAME_I(RX_MULTIFRAME_I),
        .TX_MULTIFRAME_I(TX_MULTIFRAME_I), .RX_BIT_STB_I(RX_BIT_STB_I),
        .RX_LINK_STB_I(RX_LINK_STB_I), .RX_LINK_BIT_I(RX_LINK_BIT_I),
        .RX_LINK_MATCH_I(RX_LINK_MATCH_I), .TX_LINK_EMPTY_I(TX_LINK_EMPTY_I),
        .SIG_STB_I(SIG_STB_I), .SIG_BITS_I(SIG_BITS_I), .ALARM_STATUS_I(ALARM_STATUS_I),
        .IRQ_O(IRQ_O));

    // ==========================================================
    // Clock of 10 ns period.
    always #5 CLK_I = ~CLK_I;

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Compares one observed value against its expectation; case equality rejects unknowns.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK_I);
        WR_I    <= 1'b1;
        ADDR_I  <= a;
        WDATA_I <= v;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
    endtask : wr

    // One-cycle register read; data are taken in the following cycle only.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge CLK_I);
        RD_I   <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I   <= 1'b0;
        #1 v = RDATA_O;
    endtask : rd

    // Reads the status register and compares it.
    task automatic chk_status(input logic [7:0] exp);
        rd(EVENT_STATUS_TWO_OFS, d);
        chk(d, exp);
    endtask : chk_status

    // Pulses one event input; selector 5 repeats the signaling sample unchanged.
    task automatic pulse(input int k);
        @(posedge CLK_I);
        case (k)
            0: RX_MULTIFRAME_I <= 1'b1;
            1: TX_MULTIFRAME_I <= 1'b1;
            2: RX_LINK_MATCH_I <= 1'b1;
            3: TX_LINK_EMPTY_I <= 1'b1;
            4: begin
                SIG_STB_I  <= 1'b1;
                SIG_BITS_I <= SIG_BITS_I ^ 8'h80;
            end
            default: SIG_STB_I <= 1'b1;
        endcase
        @(posedge CLK_I);
        {RX_MULTIFRAME_I, TX_MULTIFRAME_I, RX_LINK_MATCH_I, TX_LINK_EMPTY_I, SIG_STB_I} <= '0;
        repeat (3) @(posedge CLK_I);
    endtask : pulse

    // Sends n received link bits of one value, with a gap after each strobe.
    task automatic lnk(input int n, input logic b);
        repeat (n) begin
            @(posedge CLK_I);
            RX_LINK_STB_I <= 1'b1;
            RX_LINK_BIT_I <= b;
            @(posedge CLK_I);
            RX_LINK_STB_I <= 1'b0;
        end
        repeat (3) @(posedge CLK_I);
    endtask : lnk

    // Sends n receive line bit strobes.
    task automatic sec(input int n);
        repeat (n) begin
            @(posedge CLK_I);
            RX_BIT_STB_I <= 1'b1;
            @(posedge CLK_I);
            RX_BIT_STB_I <= 1'b0;
        end
        repeat (3) @(posedge CLK_I);
    endtask : sec

    // Waits a bounded time for the interrupt; running out ends the run as a failure.
    task automatic wait_irq;
        for (int k = 0; k < 8 && IRQ_O !== 1'b1; k++) begin
            @(posedge CLK_I);
            #1;
        end
        chk({7'h0, IRQ_O}, 8'h01);
        if (IRQ_O !== 1'b1) begin
            final_report();
        end
    endtask : wait_irq

    // ==========================================================
    // Main sequence: signaling prime check first, then table of events, then hand-written cases.
    initial begin
        CLK_I = 1'b0; RST_N_I = 1'b0; ADDR_I = '0; WDATA_I = '0; WR_I = 1'b0; RD_I = 1'b0;
        RX_MULTIFRAME_I = 1'b0; TX_MULTIFRAME_I = 1'b0; RX_BIT_STB_I = 1'b0;
        RX_LINK_STB_I = 1'b0; RX_LINK_BIT_I = 1'b0; RX_LINK_MATCH_I = 1'b0;
        TX_LINK_EMPTY_I = 1'b0; SIG_STB_I = 1'b0; SIG_BITS_I = '0; ALARM_STATUS_I = '0;
        err_total = 0;
        checked = 0;
        repeat (3) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        // The first signaling sample only primes; an identical one is no change.
        pulse(5);
        pulse(5);
        chk_status(8'h00);
        $display("test signaling prime done");
        // Each row: enable its bit, fire its event, see status and interrupt, clear.
        for (int r = 0; r < 5; r++) begin
            wr(EVENT_MASK_TWO_OFS, row_exp[r]);
            pulse(row_ev[r]);
            wait_irq();
            chk_status(row_exp[r]);
            wr(EVENT_STATUS_TWO_OFS, row_exp[r]);
            chk_status(8'h00);
            chk({7'h0, IRQ_O}, 8'h00);
        end
        $display("test event rows done");
        // Masked event is latched but stays silent until its mask bit opens.
        wr(EVENT_MASK_TWO_OFS, 8'h00);
        pulse(0);
        #1 chk({7'h0, IRQ_O}, 8'h00);
        wr(EVENT_MASK_TWO_OFS, 8'h80);
        wait_irq();
        // A set arriving with its own clear must win; start from a clear flag.
        wr(EVENT_STATUS_TWO_OFS, 8'h80);
        chk_status(8'h00);
        @(posedge CLK_I);
        {WR_I, RX_MULTIFRAME_I} <= 2'b11;
        ADDR_I  <= EVENT_STATUS_TWO_OFS;
        WDATA_I <= 8'h80;
        @(posedge CLK_I);
        {WR_I, RX_MULTIFRAME_I} <= 2'b00;
        repeat (3) @(posedge CLK_I);
        chk_status(8'h80);
        wr(EVENT_STATUS_TWO_OFS, 8'h80);
        chk_status(8'h00);
        $display("test mask and clear done");
        // Buffer full on the eighth bit, not the seventh.
        wr(EVENT_MASK_TWO_OFS, 8'h00);
        lnk(7, 1'b0);
        chk_status(8'h00);
        lnk(1, 1'b0);
        chk_status(8'h10);
        wr(EVENT_STATUS_TWO_OFS, 8'h10);
        // Eight ones give abort; the eighth bit also fills the buffer again.
        lnk(7, 1'b1);
        chk_status(8'h00);
        lnk(1, 1'b1);
        chk_status(8'h12);
        wr(EVENT_STATUS_TWO_OFS, 8'h12);
        // A zero inside the run breaks it: nine bits, eight ones, no abort.
        lnk(4, 1'b1);
        lnk(1, 1'b0);
        lnk(4, 1'b1);
        chk_status(8'h10);
        wr(EVENT_STATUS_TWO_OFS, 8'h10);
        $display("test data link done");
        // One-second pacing: short, short, long interval.
        for (int p = 0; p < 3; p++) begin
            sec((p == 2) ? LONG_TB - 1 : SHORT_TB - 1);
            chk_status(8'h00);
            sec(1);
            chk_status(8'h20);
            wr(EVENT_STATUS_TWO_OFS, 8'h20);
        end
        $display("test one second done");
        // Register map: event mask reads back, unmapped place ignored, idle data zero.
        wr(EVENT_MASK_TWO_OFS, 8'ha5);
        rd(EVENT_MASK_TWO_OFS, d);
        chk(d, 8'ha5);
        @(posedge CLK_I);
        #1 chk(RDATA_O, 8'h00);
        wr(8'h22, 8'hff);
        rd(8'h22, d);
        chk(d, 8'h00);
        // Each alarm bit interrupts only through its own alarm mask bit.
        for (int i = 0; i < 8; i++) begin
            wr(ALARM_MASK_ONE_OFS, 8'h01 << i);
            rd(ALARM_MASK_ONE_OFS, d);
            chk(d, 8'h01 << i);
            @(posedge CLK_I);
            ALARM_STATUS_I <= ~(8'h01 << i);
            repeat (3) @(posedge CLK_I);
            #1 chk({7'h0, IRQ_O}, 8'h00);
            @(posedge CLK_I);
            ALARM_STATUS_I <= 8'h01 << i;
            repeat (3) @(posedge CLK_I);
            #1 chk({7'h0, IRQ_O}, 8'h01);
        end
        @(posedge CLK_I);
        ALARM_STATUS_I <= 8'h00;
        $display("test alarm mask done");
        // Reset in mid-run returns every register and the interrupt to zero.
        wr(EVENT_MASK_TWO_OFS, 8'hff);
        pulse(1);
        @(posedge CLK_I);
        RST_N_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        chk_status(8'h00);
        rd(EVENT_MASK_TWO_OFS, d);
        chk(d, 8'h00);
        rd(ALARM_MASK_ONE_OFS, d);
        chk(d, 8'h00);
        chk({7'h0, IRQ_O}, 8'h00);
        $display("test reset done");
        final_report();
    end

endmodule : testbench
